//--- design/pldli_pkg.sv
package pldli_pkg;
   // ==========
   // register map (byte addresses = 4 * index)
   localparam logic [11:0] PLDLI_IDX_CTRL = 12'h000; // register zero
   localparam logic [11:0] PLDLI_IDX_KIND = 12'h03B; // indicator kind, index 59
   localparam logic [11:0] PLDLI_IDX_DELAY = 12'h03C; // lock delay, index 60
   localparam logic [11:0] PLDLI_IDX_STATUS = 12'h06E; // lock status, index 110
   localparam logic [11:0] PLDLI_IDX_NINT = 12'h080; // integer part of feedback
   localparam logic [11:0] PLDLI_IDX_NUM = 12'h081; // fraction numerator
   localparam logic [11:0] PLDLI_IDX_BOT = 12'h082; // fraction bottom
   localparam logic [11:0] PLDLI_IDX_CFG = 12'h083; // order, clock divide, extra divide
   // ==========
   // field positions
   localparam int PLDLI_CTRL_CAL_LAUNCH = 3;
   localparam int PLDLI_CTRL_PIN_SEL = 2;
   localparam int PLDLI_CTRL_MUTE = 9;
   localparam int PLDLI_KIND_BIT = 0;
   localparam int PLDLI_STATUS_LO = 9;
   localparam int PLDLI_CFG_ORDER_LO = 0;
   localparam int PLDLI_CFG_CALDIV_LO = 4;
   localparam int PLDLI_CFG_XDIV_LO = 8;
   localparam int PLDLI_CFG_SYNC = 16;
   localparam int PLDLI_CFG_DOUBLER = 17;
   localparam int PLDLI_CFG_DLYSEL_LO = 20;
   // ==========
   // reset values
   localparam logic [31:0] PLDLI_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PLDLI_DELAY_RST = 32'h0000_0000;
   localparam logic [31:0] PLDLI_NINT_RST = 32'h0000_0064;
   localparam logic [31:0] PLDLI_BOT_RST = 32'h0000_0001;
   localparam logic [31:0] PLDLI_CFG_RST = 32'h0000_0100;
   localparam logic [2:0] PLDLI_ORDER_MAX = 3'h4;
   localparam logic [2:0] PLDLI_CALDIV_MAX = 3'h4;
   localparam logic [1:0] PLDLI_RESP_OKAY = 2'h0;
   localparam logic [1:0] PLDLI_RESP_SLVERR = 2'h2;

   // ==========
   // carriers
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } pldli_wr_t;

   typedef struct packed {
      logic [31:0] nint;
      logic [31:0] num;
      logic [31:0] bot;
      logic [2:0] order;
   } pldli_frac_t;
endpackage

//--- design/pldli_modulator.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// error-feedback fractional modulator, order 0..4, one step per detector tick
module pldli_modulator
   import pldli_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic reset, // synchronous, active high
   input wire logic clear, // restart modulator state
   input wire logic step, // one detector cycle
   input wire pldli_pkg::pldli_frac_t frac, // ratio and order
   output logic [31:0] n_out // instantaneous divide value
);
   localparam int ORD = 4;
   logic [32:0] acc [ORD]; // accumulator per stage
   logic [ORD-1:0] carry; // overflow per stage
   logic [ORD-1:0] carry_d; // previous overflows
   logic signed [7:0] corr; // noise-shaping correction

   // cascaded accumulators; an unused stage holds its value, zero after reset or clear
   genvar g;
   generate
      for (g = 0; g < ORD; g++) begin : g_stage
         logic [32:0] in_val;
         logic [32:0] sum;
         assign in_val = (g == 0) ? {1'b0, frac.num} : acc[g > 0 ? g - 1 : 0];
         assign sum = acc[g] + in_val;
         assign carry[g] = (frac.order > 3'(g)) && (sum >= {1'b0, frac.bot});
         always_ff @(posedge clk) begin
            if (reset || clear) begin
               acc[g] <= '0;
               carry_d[g] <= 1'b0;
            end else if (step && frac.order > 3'(g)) begin
               acc[g] <= carry[g] ? sum - {1'b0, frac.bot} : sum;
               carry_d[g] <= carry[g];
            end
         end
      end
   endgenerate

   // simplified differencing of later-stage carries
   always_comb begin
      corr = 8'(carry[0]);
      if (frac.order > 3'h1) corr = corr + 8'(carry[1]) - 8'(carry_d[1]);
      if (frac.order > 3'h2) corr = corr + 8'(carry[2]) - 8'(carry_d[2]);
      if (frac.order > 3'h3) corr = corr + 8'(carry[3]) - 8'(carry_d[3]);
   end

   always_ff @(posedge clk) begin
      if (reset || clear) n_out <= frac.nint;
      else if (step) n_out <= frac.nint + 32'(corr); // order 0 keeps integer [RULE_06]
   end
endmodule // pldli_modulator
`default_nettype wire

//--- design/pldli_top.sv
// Functional notes
// RULE_01: doubler only while doubled reference is at most 400 MHz.
// RULE_02: post divider above one takes at most 250 MHz input.
// RULE_03: state clock is reference over two to the divide field.
// RULE_04: feedback is integer plus numerator over bottom, bottom 1..2^32-1.
// RULE_05: oscillator is detector rate times ratio times extra divide.
// RULE_06: modulator order zero (integer) to four.
// RULE_07: each register zero write resets the modulator.
// RULE_08: software keeps integer above minimum, sets delay select.
// RULE_09: extra divide is one outside sync mode.
// RULE_10: pin select zero gives readback, one gives lock indicator.
// RULE_11: kind zero picks calibration-only, one tuning plus calibration.
// RULE_12: readback pin is always driven.
// RULE_13: lock status readable at register 110 bits 10:9.
// RULE_14: calibration-only low during calibration or delay, else high; the code also holds it low before the first launch.
// RULE_15: delay is 16-bit count of detector cycles.
// RULE_16: calibration-only holds until launch write with valid reference.
// RULE_17: tuning high only when calibrated, timer expired, locked.
// RULE_18: tuning indicator freezes while reference is absent.
// RULE_19: mute enable mutes output while tuning indicator low.
// RULE_20: register zero write with launch bit starts calibration.
// RULE_21: delay counter restarts per calibration, counts after completion.
`timescale 1ns/1ps
`default_nettype none
module pldli_top
   import pldli_pkg::*;
#(
   parameter int DELAY_W = 16, // lock delay width
   parameter int CAL_CYCLES = 64 // state-machine ticks a calibration lasts
) (
   input wire logic clk, // 40 MHz system clock
   input wire logic reset, // synchronous, active high
   input wire logic [13:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [13:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic ref_tick, // one pulse per reference edge
   input wire logic ref_valid, // reference present
   input wire logic pd_tick, // one pulse per detector cycle
   input wire logic loop_locked, // analog lock comparator
   input wire logic readback_data, // serial readback bit
   output logic multi_function_output_pin, // readback or lock indicator
   output logic multi_function_output_pin_oe, // pin enable
   output logic rf_mute, // mute the output stage
   output logic sm_tick, // divided state-machine clock enable
   output logic [31:0] n_value, // instantaneous feedback divide
   output logic [7:0] sync_extra_divide, // extra divide in sync mode
   output logic reference_doubler, // doubler enable
   output logic [2:0] detector_delay_select // delay select to detector
);
   import pldli_pkg::*;

   // ==========
   // bus slave
   logic [31:0] ctrl_r, kind_r, delay_r, nint_r, num_r, bot_r, cfg_r;
   logic aw_held, w_held;
   logic [11:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic cal_busy, timer_run, cal_only_ind, tune_ind;
   logic [1:0] lock_status_readback;

   // either channel may arrive first; each is held until both are present
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   logic aw_fire, w_fire, wr_go;
   pldli_wr_t wr;
   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire = s_axi_wvalid && s_axi_wready;
   assign wr_go = (aw_held || aw_fire) && (w_held || w_fire);
   assign wr.addr = aw_held ? aw_idx : s_axi_awaddr[13:2];
   assign wr.data = w_held ? w_data : s_axi_wdata;
   assign wr.strb = w_held ? w_strb : s_axi_wstrb;

   logic wr_known;
   assign wr_known = wr.addr inside {PLDLI_IDX_CTRL, PLDLI_IDX_KIND, PLDLI_IDX_DELAY,
      PLDLI_IDX_STATUS, PLDLI_IDX_NINT, PLDLI_IDX_NUM, PLDLI_IDX_BOT, PLDLI_IDX_CFG};

   // byte-lane merge for the addressed register
   function automatic logic [31:0] merge(input logic [31:0] old, input pldli_wr_t w);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (w.strb[b]) res[b*8 +: 8] = w.data[b*8 +: 8];
      end
      return res;
   endfunction

   always_ff @(posedge clk) begin
      if (reset) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PLDLI_RESP_OKAY;
      end else begin
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? PLDLI_RESP_OKAY : PLDLI_RESP_SLVERR;
         end else begin
            if (aw_fire) begin
               aw_held <= 1'b1;
               aw_idx <= s_axi_awaddr[13:2];
            end
            if (w_fire) begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
               w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register writes; status register is read only
   logic ctrl_wr;
   assign ctrl_wr = wr_go && wr.addr == PLDLI_IDX_CTRL;
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r <= PLDLI_CTRL_RST;
         kind_r <= '0;
         delay_r <= PLDLI_DELAY_RST;
         nint_r <= PLDLI_NINT_RST;
         num_r <= '0;
         bot_r <= PLDLI_BOT_RST;
         cfg_r <= PLDLI_CFG_RST;
      end else if (wr_go) begin
         case (wr.addr)
            PLDLI_IDX_CTRL: ctrl_r <= merge(ctrl_r, wr);
            PLDLI_IDX_KIND: kind_r <= merge(kind_r, wr) & 32'h0000_0001;
            PLDLI_IDX_DELAY: delay_r <= merge(delay_r, wr) & 32'h0000_FFFF; // [RULE_15]
            PLDLI_IDX_NINT: nint_r <= merge(nint_r, wr);
            PLDLI_IDX_NUM: num_r <= merge(num_r, wr);
            PLDLI_IDX_BOT: bot_r <= merge(bot_r, wr);
            PLDLI_IDX_CFG: cfg_r <= merge(cfg_r, wr);
            default: ;
         endcase
      end
   end

   // read mux
   logic [11:0] rd_idx;
   logic [31:0] rd_val;
   logic rd_known;
   assign rd_idx = s_axi_araddr[13:2];
   always_comb begin
      rd_known = 1'b1;
      case (rd_idx)
         PLDLI_IDX_CTRL: rd_val = ctrl_r;
         PLDLI_IDX_KIND: rd_val = kind_r;
         PLDLI_IDX_DELAY: rd_val = delay_r;
         PLDLI_IDX_STATUS: rd_val = 32'(lock_status_readback) << PLDLI_STATUS_LO; // [RULE_13]
         PLDLI_IDX_NINT: rd_val = nint_r;
         PLDLI_IDX_NUM: rd_val = num_r;
         PLDLI_IDX_BOT: rd_val = bot_r;
         PLDLI_IDX_CFG: rd_val = cfg_r;
         default: begin
            rd_val = '0;
            rd_known = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= PLDLI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_known ? PLDLI_RESP_OKAY : PLDLI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========
   // configuration fields
   logic [2:0] order_f, caldiv_f;
   logic sync_mode;
   assign order_f = cfg_r[PLDLI_CFG_ORDER_LO +: 3] > PLDLI_ORDER_MAX ? PLDLI_ORDER_MAX
                    : cfg_r[PLDLI_CFG_ORDER_LO +: 3]; // [RULE_06]
   assign caldiv_f = cfg_r[PLDLI_CFG_CALDIV_LO +: 3] > PLDLI_CALDIV_MAX ? PLDLI_CALDIV_MAX
                     : cfg_r[PLDLI_CFG_CALDIV_LO +: 3];
   assign sync_mode = cfg_r[PLDLI_CFG_SYNC];
   // doubler and delay select are passed on; limits are software's job [RULE_01] [RULE_08]
   assign reference_doubler = cfg_r[PLDLI_CFG_DOUBLER];
   assign detector_delay_select = cfg_r[PLDLI_CFG_DLYSEL_LO +: 3];

   // extra divide forced to one outside sync mode; zero reads as one
   always_ff @(posedge clk) begin
      if (reset) sync_extra_divide <= 8'h01;
      else if (!sync_mode || cfg_r[PLDLI_CFG_XDIV_LO +: 8] == 8'h00)
         sync_extra_divide <= 8'h01; // [RULE_09] [RULE_05]
      else sync_extra_divide <= cfg_r[PLDLI_CFG_XDIV_LO +: 8];
   end

   // ==========
   // state-machine clock divider: reference / 2^caldiv
   logic [15:0] ref_cnt;
   logic [15:0] div_mask;
   assign div_mask = 16'((32'h1 << caldiv_f) - 32'h1);
   assign sm_tick = ref_tick && ((ref_cnt & div_mask) == 16'h0000); // [RULE_03]
   always_ff @(posedge clk) begin
      if (reset) ref_cnt <= '0;
      else if (ref_tick) ref_cnt <= ref_cnt + 16'h0001;
   end

   // ==========
   // fractional feedback
   pldli_frac_t frac;
   assign frac.nint = nint_r;
   assign frac.num = num_r;
   assign frac.bot = (bot_r == 32'h0) ? PLDLI_BOT_RST : bot_r; // [RULE_04]
   assign frac.order = order_f;

   pldli_modulator u_mod (
      .clk(clk),
      .reset(reset),
      .clear(ctrl_wr), // [RULE_07]
      .step(pd_tick),
      .frac(frac),
      .n_out(n_value) // [RULE_05]
   );

   // ==========
   // calibration sequencer and lock delay timer
   typedef enum logic [1:0] {PLDLI_IDLE, PLDLI_CAL, PLDLI_WAIT, PLDLI_DONE} pldli_state_t;
   pldli_state_t state, next_state;
   logic [15:0] cal_cnt;
   logic [DELAY_W-1:0] dly_cnt;
   logic [31:0] ctrl_new;
   logic launch;
   assign ctrl_new = merge(ctrl_r, wr);
   assign launch = ctrl_wr && ctrl_new[PLDLI_CTRL_CAL_LAUNCH] && ref_valid; // [RULE_20] [RULE_16]

   always_comb begin
      next_state = state;
      case (state)
         PLDLI_IDLE: ;
         PLDLI_CAL: if (sm_tick && cal_cnt == 16'(CAL_CYCLES - 1)) next_state = PLDLI_WAIT;
         PLDLI_WAIT: if (dly_cnt >= delay_r[DELAY_W-1:0]) next_state = PLDLI_DONE; // [RULE_15]
         PLDLI_DONE: ;
         default: next_state = PLDLI_IDLE;
      endcase
      if (launch) next_state = PLDLI_CAL;
   end

   always_ff @(posedge clk) begin
      if (reset) state <= PLDLI_IDLE;
      else state <= next_state;
   end

   // calibration tick count, restarted by each launch
   always_ff @(posedge clk) begin
      if (reset || launch) cal_cnt <= '0;
      else if (state == PLDLI_CAL && sm_tick) cal_cnt <= cal_cnt + 16'h0001;
   end

   // timer counts detector cycles only once calibration has ended
   always_ff @(posedge clk) begin
      if (reset || launch) dly_cnt <= '0; // [RULE_21]
      else if (state == PLDLI_WAIT && pd_tick) dly_cnt <= dly_cnt + 1'b1; // [RULE_21]
   end

   assign cal_busy = state == PLDLI_CAL;
   assign timer_run = state == PLDLI_WAIT;

   // ==========
   // indicators; cal-only changes only with the sequencer, so it holds [RULE_16]
   assign cal_only_ind = !(cal_busy || timer_run) && state != PLDLI_IDLE; // [RULE_14]
   always_ff @(posedge clk) begin
      if (reset) tune_ind <= 1'b0;
      else if (ref_valid) tune_ind <= state == PLDLI_DONE && loop_locked; // [RULE_17] [RULE_18]
   end
   assign lock_status_readback = {tune_ind, cal_only_ind};

   // pin function select; always driven in both functions
   logic pin_next;
   assign pin_next = !ctrl_r[PLDLI_CTRL_PIN_SEL] ? readback_data // [RULE_10]
                     : (kind_r[PLDLI_KIND_BIT] ? tune_ind : cal_only_ind); // [RULE_11]
   assign multi_function_output_pin_oe = 1'b1; // [RULE_12]
   always_ff @(posedge clk) begin
      if (reset) begin
         multi_function_output_pin <= 1'b0;
         rf_mute <= 1'b0;
      end else begin
         multi_function_output_pin <= pin_next;
         rf_mute <= ctrl_r[PLDLI_CTRL_MUTE] && !tune_ind; // [RULE_19]
      end
   end
endmodule // pldli_top
`default_nettype wire

//--- verif/pldli_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// reference and detector tick source facing the block
module pldli_front_model (
   input wire logic clk, // system clock
   input wire logic ref_on, // reference present
   input wire logic [3:0] pd_period, // cycles per detector tick
   output logic ref_tick, // reference edge pulse
   output logic ref_valid, // reference present flag
   output logic pd_tick // detector cycle pulse
);
   logic [3:0] cnt = 4'h0;
   // ticks stop dead while the reference is gone, no free-running edges
   always @(posedge clk) begin
      ref_valid <= ref_on;
      ref_tick <= ref_on;
      cnt <= (cnt + 4'h1 >= pd_period) ? 4'h0 : cnt + 4'h1; // divided reference
      pd_tick <= ref_on && (cnt == 4'h0);
   end
endmodule // pldli_front_model
`default_nettype wire

//--- verif/pldli_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bus and pin relations seen at the top ports
module pldli_top_props
   import pldli_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic reset, // synchronous reset
   input wire logic s_axi_awvalid, // write address valid
   input wire logic s_axi_awready, // write address ready
   input wire logic s_axi_wvalid, // write data valid
   input wire logic s_axi_wready, // write data ready
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address ready
   input wire logic [1:0] s_axi_rresp, // read response
   input wire logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic ref_tick, // reference edge pulse
   input wire logic sm_tick, // divided clock enable
   input wire logic multi_function_output_pin_oe // pin enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ==========
   // read request taken, then the answer
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_rd_answer;
      s_axi_rvalid && (s_axi_rresp == PLDLI_RESP_OKAY || s_axi_rresp == PLDLI_RESP_SLVERR);
   endsequence
   property p_rd_answer;
      s_rd_take |=> s_rd_answer;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late or bad");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
   property p_wr_cause;
      $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready);
   endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("write answer without request");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer not held");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
   property p_sm_tick;
      sm_tick |-> ref_tick;
   endproperty
   a_sm_tick: assert property (p_sm_tick) else $error("state tick without reference edge");
   property p_oe;
      multi_function_output_pin_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin released");
endmodule // pldli_top_props
bind pldli_top pldli_top_props i_pldli_top_props (.*);
`default_nettype wire

//--- verif/tb_pldli_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pldli_top;
   import pldli_pkg::*;
   localparam int CAL = 8;
   localparam int DLY = 6;
   logic clk = 1'b0, reset = 1'b1, awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
   logic lk = 1'b1, rbd = 1'b0, ref_on = 1'b1;
   logic [13:0] awa = 14'h0000, ara = 14'h0000;
   logic [31:0] wd = 32'h0000_0000, rd, nv;
   logic [3:0] ws = 4'h0, pdp = 4'h2;
   logic [1:0] br, rr;
   logic awr, wr_rdy, bv, arr, rv, rtk, rvl, ptk, pin, oe, mute, smt, dbl;
   logic [7:0] xd;
   logic [2:0] dls;
   int miscompares = 0, compares = 0, cyc = 0;
   always #12.5 clk = ~clk;
   pldli_top #(.CAL_CYCLES(CAL)) i_pldli_top (.clk(clk), .reset(reset), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
      .ref_tick(rtk), .ref_valid(rvl), .pd_tick(ptk), .loop_locked(lk), .readback_data(rbd),
      .multi_function_output_pin(pin), .multi_function_output_pin_oe(oe), .rf_mute(mute),
      .sm_tick(smt), .n_value(nv), .sync_extra_divide(xd), .reference_doubler(dbl),
      .detector_delay_select(dls));
   pldli_front_model i_pldli_front_model (.clk(clk), .ref_on(ref_on), .pd_period(pdp),
      .ref_tick(rtk), .ref_valid(rvl), .pd_tick(ptk));
   // =====================================================
   // shared helpers
   function automatic logic [13:0] ba(input logic [11:0] idx);
      return {idx, 2'b00};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // write address and data offered together, each released when taken
   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      @(posedge clk);
      awa <= ba(idx);
      awv <= 1'b1;
      wd <= d;
      ws <= 4'hF;
      wv <= 1'b1;
      brd <= 1'b1;
      do begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_rdy === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1);
      brd <= 1'b0;
      check("bresp", br, PLDLI_RESP_OKAY);
   endtask
   task automatic rdc(input logic [13:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rrd <= 1'b0;
      check("rdata", rd & m, e);
      check("rresp", rr, er);
   endtask
   // waits for the indicator, returns cycles spent low
   task automatic wait_high(output int n);
      n = 0;
      @(negedge clk);
      while (pin !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask
   // =====================================================
   // scenarios
   task automatic t_reset;
      @(negedge clk);
      check("xdiv", xd, 8'h01);
      check("nval", nv, PLDLI_NINT_RST);
      check("mute", mute, 1'b0);
      rdc(ba(PLDLI_IDX_CTRL), 32'hFFFF_FFFF, PLDLI_CTRL_RST, PLDLI_RESP_OKAY);
      rdc(ba(PLDLI_IDX_DELAY), 32'hFFFF_FFFF, PLDLI_DELAY_RST, PLDLI_RESP_OKAY);
      rdc(ba(PLDLI_IDX_BOT), 32'hFFFF_FFFF, PLDLI_BOT_RST, PLDLI_RESP_OKAY);
      rdc(ba(PLDLI_IDX_CFG), 32'hFFFF_FFFF, PLDLI_CFG_RST, PLDLI_RESP_OKAY);
      rdc(ba(PLDLI_IDX_STATUS), 32'h0000_0600, 32'h0, PLDLI_RESP_OKAY);
      rdc(14'h3FC, 32'hFFFF_FFFF, 32'h0, PLDLI_RESP_SLVERR);
      $display("test reset done");
   endtask
   task automatic t_readback;
      wr(PLDLI_IDX_CTRL, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rbd <= ~i[0];
         @(posedge clk);
         @(negedge clk);
         check("pin_rb", pin, !i[0]);
         check("oe", oe, 1'b1);
      end
      @(posedge clk);
      rbd <= 1'b0;
      $display("test readback done");
   endtask
   task automatic t_cal_only;
      int n;
      wr(PLDLI_IDX_KIND, 32'h0);
      wr(PLDLI_IDX_DELAY, DLY);
      wr(PLDLI_IDX_CTRL, 32'h0000_000C);
      wait_high(n);
      check("cal_low", n >= CAL + 2 * DLY - 3 && n <= CAL + 2 * DLY + 4, 1'b1);
      check("no_mute", mute, 1'b0);
      @(posedge clk);
      ref_on <= 1'b0;
      lk <= 1'b0;
      wr(PLDLI_IDX_CTRL, 32'h0000_000C);
      repeat (10) @(posedge clk);
      @(negedge clk);
      check("cal_hold", pin, 1'b1);
      @(posedge clk);
      ref_on <= 1'b1;
      lk <= 1'b1;
      rdc(ba(PLDLI_IDX_STATUS), 32'h0000_0200, 32'h0000_0200, PLDLI_RESP_OKAY);
      wr(PLDLI_IDX_CTRL, 32'h0000_000C);
      @(negedge clk);
      check("relaunch", pin, 1'b0);
      wait_high(n);
      check("relaunch_t", n <= CAL + 2 * DLY + 4, 1'b1);
      $display("test calibration indicator done");
   endtask
   task automatic t_tune;
      @(posedge clk);
      lk <= 1'b0;
      wr(PLDLI_IDX_KIND, 32'h1);
      wr(PLDLI_IDX_CTRL, 32'h0000_020C);
      repeat (CAL + 2 * DLY + 10) @(posedge clk);
      @(negedge clk);
      check("tune_unlk", pin, 1'b0);
      check("mute_on", mute, 1'b1);
      @(posedge clk);
      lk <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("tune_lk", pin, 1'b1);
      check("mute_off", mute, 1'b0);
      rdc(ba(PLDLI_IDX_STATUS), 32'h0000_0600, 32'h0000_0600, PLDLI_RESP_OKAY);
      @(posedge clk);
      ref_on <= 1'b0;
      repeat (3) @(posedge clk);
      lk <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("frozen", pin, 1'b1);
      @(posedge clk);
      ref_on <= 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check("resumed", pin, 1'b0);
      @(posedge clk);
      lk <= 1'b1;
      $display("test tuning indicator done");
   endtask
   task automatic t_cfg;
      int n;
      for (int k = 0; k <= 4; k++) begin
         wr(PLDLI_IDX_CFG, 32'h0050_0400 | (k << 4)); // doubler kept off
         n = 0;
         repeat (64) begin
            @(negedge clk);
            n += (smt === 1'b1);
         end
         check("smclk", n, 64 >> k);
      end
      check("xdiv_off", xd, 8'h01);
      check("dlysel", dls, 3'h5);
      wr(PLDLI_IDX_CFG, 32'h0063_0400);
      @(negedge clk);
      check("xdiv_on", xd, 8'h04);
      check("dbl", dbl, 1'b1);
      $display("test config done");
   endtask
   task automatic t_mod;
      int s[2];
      @(posedge clk);
      pdp <= 4'h1;
      wr(PLDLI_IDX_NINT, 32'd40); // kept above the minimum
      wr(PLDLI_IDX_NUM, 32'd1);
      wr(PLDLI_IDX_BOT, 32'd2);
      for (int o = 0; o <= 4; o++) begin
         wr(PLDLI_IDX_CFG, o);
         for (int r = 0; r < 2; r++) begin
            wr(PLDLI_IDX_CTRL, 32'h0);
            s[r] = 0;
            repeat (32) begin
               @(negedge clk);
               s[r] += int'(nv);
            end
         end
         check("repeat", s[1], s[0]);
         if (o == 0) check("int_mode", s[0], 32 * 40);
         else check("frac_avg", s[0] >= 1288 && s[0] <= 1304, 1'b1);
      end
      $display("test modulator done");
   endtask
   // =====================================================
   // closing report, reached from the sequence or the watchdog
   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog, well beyond the roughly one thousand cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_readback();
      t_cal_only();
      t_tune();
      t_cfg();
      t_mod();
      print_verdict();
   end
endmodule // tb_pldli_top
`default_nettype wire
